/* File: fwi_pkg.sv */
package fwi_pkg;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FWI_MODE_RESET,
        FWI_MODE_NORMAL_REQ,
        FWI_MODE_NORMAL,
        FWI_MODE_STOP,
        FWI_MODE_SLEEP
    } fwi_mode_t;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_KHZ = 25000;
    localparam int NREQ_TIMEOUT_MS = 150;
    localparam int NREQ_TIMEOUT_CYC = NREQ_TIMEOUT_MS * CLK_KHZ;
    localparam int NREQ_CNT_W = 22;
    localparam int LIN_WAKE_US = 100;
    localparam int LIN_WAKE_CYC = LIN_WAKE_US * CLK_KHZ / 1000;
    localparam int LIN_CNT_W = 12;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_CNT_W = 8;
    localparam int IRQ_PEND_W = 4;

    // ----------------------------------------------------------------
    // Status byte layout
    // ----------------------------------------------------------------
    localparam int ST_SRC_BIT = 7;
    localparam int ST_LIN_BIT = 6;
    localparam int ST_OV_BIT = 5;
    localparam int ST_UV_BIT = 4;
    localparam int ST_RH_BIT = 3;
    localparam int ST_HS_BIT = 2;
    localparam int ST_L2_BIT = 1;
    localparam int ST_L1_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int HS_NUM = 3;
    localparam logic [2:0] HS_ON_RESET = 3'h0;

endpackage

/* File: fwi_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fwi_irq_if;
    logic evt;
    logic busy;
    logic irq_n;
    modport src (output evt, input busy, input irq_n);
    modport gen (input evt, output busy, output irq_n);
endinterface
`default_nettype wire

/* File: fwi_irq_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
module fwi_irq_pulse #(
    parameter int WIDTH = fwi_pkg::IRQ_PULSE_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    fwi_irq_if.gen irq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [fwi_pkg::IRQ_CNT_W-1:0] cnt;
        logic [fwi_pkg::IRQ_PEND_W-1:0] pend;
        logic irq_n;
    } fwi_pulse_t;

    fwi_pulse_t q;
    fwi_pulse_t n;
    logic start;

    // Events that arrive while a pulse runs are queued, up to 15 pending, so that each one
    // still gets its own pulse, separated by at least one high cycle.
    always_comb begin
        n = q;
        start = (q.cnt == '0) && q.irq_n && ((q.pend != '0) || irq.evt);
        if (q.cnt != '0) begin
            n.cnt = q.cnt - 1'b1;
            if (q.cnt == 1) begin
                n.irq_n = 1'b1;
            end
        end else if (start) begin
            n.cnt = fwi_pkg::IRQ_CNT_W'(WIDTH);
            n.irq_n = 1'b0;
        end
        if (irq.evt && !start && (q.pend != '1)) begin
            n.pend = q.pend + 1'b1;
        end else if (!irq.evt && start) begin
            n.pend = q.pend - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '{cnt: '0, pend: '0, irq_n: 1'b1};
        end else begin
            q <= n;
        end
    end

    assign irq.irq_n = q.irq_n;
    assign irq.busy = !q.irq_n || (q.pend != '0);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence idle_evt_s;
        irq.evt && q.irq_n && (q.cnt == '0) && (q.pend == '0);
    endsequence

    sequence low_run_s;
        (!irq.irq_n) [*8];
    endsequence

    pulse_low_run_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        idle_evt_s |=> low_run_s)
        else $error("interrupt pulse did not start or ended too early");

    pulse_width_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $fell(irq.irq_n) |-> ##WIDTH irq.irq_n)
        else $error("interrupt pulse width is wrong");
endmodule
`default_nettype wire

/* File: fwi_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - In Normal mode four fault sources each pulse the interrupt line.
// - No fault interrupt can be masked or disabled.
// - After an interrupt the source flag makes the next status read report the source.
// - Supply under-voltage sets its flag and interrupts; flag follows the condition.
// - Supply over-voltage sets its flag and interrupts; flag follows the condition.
// - Sleep and Stop disable all four fault detectors.
// - In Stop, wake inputs and LIN wake pulse the interrupt line, unmaskable.
// - A wake-up source is reported once, then the source flag clears itself.
// - Regulator over-temperature prewarning sets its flag and interrupts.
// - Any high-side over-temperature turns all switches off, sets flag, interrupts.
// - High-side thermal shutdown latches off; no automatic restart.
// - Reset mode: reset low, watchdog, switches, LIN transmit and amplifier off.
// - Normal Request: reset high, 150 ms timeout if watchdog enabled, amplifier off.
// - Normal: reset high, window watchdog if enabled, everything active.
// - Stop: limited regulator, reset high, wakes on LIN, wake inputs, select rise.
// - Sleep: regulator off, reset low, wakes on LIN or wake inputs only.
// - LIN transmitter is enabled only in Normal and Normal Request.
// - Status byte: source flag, LIN, over, under, regulator, high-side, wake levels.
// - In Stop a long dominant LIN level then rising edge wakes and flags.
module fwi_top #(
    parameter int NREQ_TIMEOUT_CYC = fwi_pkg::NREQ_TIMEOUT_CYC,
    parameter int LIN_WAKE_CYC = fwi_pkg::LIN_WAKE_CYC,
    parameter int IRQ_PULSE_CYC = fwi_pkg::IRQ_PULSE_CYC
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire fwi_pkg::fwi_mode_t mode_i,
    input wire logic watchdog_cfg_en_i,
    input wire logic undervolt_det_i,
    input wire logic overvolt_det_i,
    input wire logic regulator_hot_det_i,
    input wire logic [fwi_pkg::HS_NUM-1:0] highside_hot_det_i,
    input wire logic lin_fail_det_i,
    input wire logic wake_input_one_i,
    input wire logic wake_input_two_i,
    input wire logic lin_rx_i,
    input wire logic spi_select_n_i,
    input wire logic status_read_i,
    input wire logic highside_on_wr_i,
    input wire logic [fwi_pkg::HS_NUM-1:0] highside_on_bits_i,
    output logic [7:0] status_byte_o,
    output logic fault_irq_n_o,
    output logic analog_reset_n_o,
    output logic regulator_on_o,
    output logic regulator_limit_o,
    output logic watchdog_en_o,
    output logic watchdog_window_o,
    output logic watchdog_timeout_o,
    output logic [fwi_pkg::HS_NUM-1:0] highside_en_o,
    output logic lin_tx_en_o,
    output logic lin_wake_en_o,
    output logic amp_en_o,
    output logic wake_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] s_uv;
        logic [1:0] s_ov;
        logic [1:0] s_rh;
        logic [1:0] s_lf;
        logic [1:0] s_l1;
        logic [1:0] s_l2;
        logic [1:0] s_lin;
        logic [1:0] s_ss;
        logic [fwi_pkg::HS_NUM-1:0] s_hs0;
        logic [fwi_pkg::HS_NUM-1:0] s_hs1;
        logic uv_p;
        logic ov_p;
        logic rh_p;
        logic hs_p;
        logic lf_p;
        logic l1_p;
        logic l2_p;
        logic lin_p;
        logic ss_p;
        logic lin_evt;
        logic src_v;
        logic [6:0] src;
        logic [7:0] status;
        logic hs_latch;
        logic hs_rd_ok;
        logic [fwi_pkg::HS_NUM-1:0] hs_on;
        logic [fwi_pkg::LIN_CNT_W-1:0] lin_cnt;
        logic [fwi_pkg::NREQ_CNT_W-1:0] nreq_cnt;
        logic wd_to;
        logic wake;
    } fwi_state_t;

    fwi_state_t q;
    fwi_state_t n;
    fwi_irq_if irq ();

    logic m_reset, m_nreq, m_norm, m_stop, m_sleep, m_low;
    logic det_on, uv, ov, rh, hs, lf;
    logic uv_new, ov_new, rh_new, hs_new, lf_new;
    logic l1w, l2w, linw, ssw;
    logic evt_fault, evt_wake;
    logic [6:0] src_new;
    logic [7:0] live;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    always_comb begin
        m_reset = 1'b0;
        m_nreq = 1'b0;
        m_norm = 1'b0;
        m_stop = 1'b0;
        m_sleep = 1'b0;
        unique case (mode_i)
            fwi_pkg::FWI_MODE_RESET: m_reset = 1'b1;
            fwi_pkg::FWI_MODE_NORMAL_REQ: m_nreq = 1'b1;
            fwi_pkg::FWI_MODE_NORMAL: m_norm = 1'b1;
            fwi_pkg::FWI_MODE_STOP: m_stop = 1'b1;
            fwi_pkg::FWI_MODE_SLEEP: m_sleep = 1'b1;
            default: m_reset = 1'b1;
        endcase
        m_low = m_stop || m_sleep;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        n.s_uv = {q.s_uv[0], undervolt_det_i};
        n.s_ov = {q.s_ov[0], overvolt_det_i};
        n.s_rh = {q.s_rh[0], regulator_hot_det_i};
        n.s_lf = {q.s_lf[0], lin_fail_det_i};
        n.s_l1 = {q.s_l1[0], wake_input_one_i};
        n.s_l2 = {q.s_l2[0], wake_input_two_i};
        n.s_lin = {q.s_lin[0], lin_rx_i};
        n.s_ss = {q.s_ss[0], spi_select_n_i};
        n.s_hs0 = highside_hot_det_i;
        n.s_hs1 = q.s_hs0;

        det_on = !m_low;
        uv = det_on && q.s_uv[1];
        ov = det_on && q.s_ov[1];
        rh = det_on && q.s_rh[1];
        hs = det_on && (|q.s_hs1);
        lf = !m_low && q.s_lf[1];
        uv_new = uv && !q.uv_p;
        ov_new = ov && !q.ov_p;
        rh_new = rh && !q.rh_p;
        hs_new = hs && !q.hs_p;
        lf_new = lf && !q.lf_p;
        n.uv_p = uv;
        n.ov_p = ov;
        n.rh_p = rh;
        n.hs_p = hs;
        n.lf_p = lf;

        // Wake inputs report any level change; LIN needs a long dominant phase.
        l1w = m_low && (q.s_l1[1] != q.l1_p);
        l2w = m_low && (q.s_l2[1] != q.l2_p);
        linw = m_low && q.s_lin[1] && !q.lin_p
            && (q.lin_cnt >= fwi_pkg::LIN_CNT_W'(LIN_WAKE_CYC));
        ssw = m_stop && q.s_ss[1] && !q.ss_p;
        n.l1_p = q.s_l1[1];
        n.l2_p = q.s_l2[1];
        n.lin_p = q.s_lin[1];
        n.ss_p = q.s_ss[1];
        if (m_low && !q.s_lin[1]) begin
            if (q.lin_cnt != '1) begin
                n.lin_cnt = q.lin_cnt + 1'b1;
            end
        end else begin
            n.lin_cnt = '0;
        end
        n.wake = l1w || l2w || linw || ssw;

        // No mask exists: every new fault in Normal except LIN failure reaches the pulse generator.
        evt_fault = m_norm && (uv_new || ov_new || rh_new || hs_new);
        evt_wake = m_stop && (l1w || l2w || linw);
        src_new = {linw || lf_new, ov_new, uv_new, rh_new, hs_new, l2w, l1w};

        live = {1'b0, q.lin_evt, ov, uv, rh, hs || q.hs_latch, q.s_l2[1], q.s_l1[1]};

        if (status_read_i) begin
            n.status = q.src_v ? {1'b1, q.src} : live;
            n.src_v = 1'b0;
            if (q.lin_evt) begin
                n.lin_evt = 1'b0;
            end
            if (live[fwi_pkg::ST_HS_BIT] || (q.src_v && q.src[fwi_pkg::ST_HS_BIT])) begin
                n.hs_rd_ok = q.hs_latch;
            end
        end
        // A new event wins over the clear done by a read in the same cycle.
        if (linw || lf_new) begin
            n.lin_evt = 1'b1;
        end
        if (evt_fault || evt_wake) begin
            n.src_v = 1'b1;
            n.src = (q.src_v && !status_read_i) ? (q.src | src_new) : src_new;
        end

        // Thermal shutdown stays latched until software reads and rewrites.
        if (highside_on_wr_i) begin
            if (!q.hs_latch) begin
                n.hs_on = highside_on_bits_i;
            end else if (q.hs_rd_ok && !hs && (|highside_on_bits_i)) begin
                n.hs_latch = 1'b0;
                n.hs_rd_ok = 1'b0;
                n.hs_on = highside_on_bits_i;
            end
        end
        if (hs_new) begin
            n.hs_latch = 1'b1;
            n.hs_rd_ok = 1'b0;
            n.hs_on = fwi_pkg::HS_ON_RESET;
        end

        // Normal Request supervision.
        n.wd_to = 1'b0;
        if (m_nreq && watchdog_cfg_en_i) begin
            if (q.nreq_cnt == fwi_pkg::NREQ_CNT_W'(NREQ_TIMEOUT_CYC - 1)) begin
                n.nreq_cnt = '0;
                n.wd_to = 1'b1;
            end else begin
                n.nreq_cnt = q.nreq_cnt + 1'b1;
            end
        end else begin
            n.nreq_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // Idle-high pins start high, so a release in Stop makes no false edge.
            q <= '{s_lin: 2'h3, s_ss: 2'h3, lin_p: 1'b1, ss_p: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------
    // Pulse generator and outputs
    // ----------------------------------------------------------------
    assign irq.evt = evt_fault || evt_wake;

    fwi_irq_pulse #(
        .WIDTH(IRQ_PULSE_CYC)
    ) u_pulse (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .irq(irq)
    );

    assign fault_irq_n_o = irq.irq_n;
    assign status_byte_o = q.status;
    assign analog_reset_n_o = m_nreq || m_norm || m_stop;
    assign regulator_on_o = !m_sleep;
    assign regulator_limit_o = m_stop;
    assign watchdog_en_o = watchdog_cfg_en_i && (m_nreq || m_norm);
    assign watchdog_window_o = watchdog_cfg_en_i && m_norm;
    assign watchdog_timeout_o = q.wd_to;
    assign highside_en_o = (m_nreq || m_norm) && !q.hs_latch ? q.hs_on : '0;
    assign lin_tx_en_o = m_nreq || m_norm;
    assign lin_wake_en_o = m_low;
    assign amp_en_o = m_norm;
    assign wake_o = q.wake;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    fault_irq_unmasked_a: assert property (
        (m_norm && (uv_new || ov_new || rh_new || hs_new)) |=> irq.busy)
        else $error("fault in normal mode gave no interrupt request");

    low_power_quiet_a: assert property (
        (m_low && status_read_i && !q.src_v) |=> (status_byte_o[5:3] == 3'h0))
        else $error("fault detection active in low power mode");

    source_set_a: assert property (
        irq.evt |=> q.src_v)
        else $error("source flag not set after interrupt");

    source_once_a: assert property (
        (status_read_i && q.src_v && !irq.evt) |=> (!q.src_v && status_byte_o[7]))
        else $error("source not reported once then cleared");

    stop_wake_irq_a: assert property (
        (m_stop && (l1w || l2w || linw)) |-> irq.evt ##1 q.src_v)
        else $error("stop mode wake gave no interrupt");

    highside_shutdown_a: assert property (
        hs_new |=> (highside_en_o == '0) && q.hs_latch)
        else $error("high side switches not shut down");

    reset_mode_outs_a: assert property (
        m_reset |-> !analog_reset_n_o && !watchdog_en_o && !lin_tx_en_o
            && !amp_en_o && (highside_en_o == '0))
        else $error("reset mode outputs wrong");

    lin_tx_modes_a: assert property (
        lin_tx_en_o |-> (m_nreq || m_norm))
        else $error("lin transmitter enabled outside normal modes");

    status_live_a: assert property (
        (status_read_i && !q.src_v) |=> !status_byte_o[7]
            && (status_byte_o[5] == $past(ov)) && (status_byte_o[4] == $past(uv)))
        else $error("live status byte wrong");

    timeout_mode_a: assert property (
        q.wd_to |-> $past(m_nreq) && $past(watchdog_cfg_en_i))
        else $error("timeout outside normal request");
endmodule
`default_nettype wire

/* File: fwi_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fwi_mcu_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic fault_irq_n_i,
    input wire logic [7:0] status_byte_i,
    output var logic status_read_o,
    output var logic highside_on_wr_o,
    output var logic [2:0] highside_on_bits_o
);
    // --------
    // Interrupt pulse counting
    // --------
    // The pin is sampled on the clock, so a pulse shorter than a cycle
    // would be missed; the device is built never to make one.
    int pulse_cnt;
    logic irq_n_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_n_q <= 1'b1;
            pulse_cnt <= 0;
        end else begin
            irq_n_q <= fault_irq_n_i;
            if (irq_n_q && !fault_irq_n_i) begin
                pulse_cnt <= pulse_cnt + 1;
            end
        end
    end

    // --------
    // Register transfers
    // --------
    initial begin
        status_read_o = 1'b0;
        highside_on_wr_o = 1'b0;
        highside_on_bits_o = 3'h0;
    end

    // Called just after a rising edge; the byte is taken one edge later.
    // One idle edge follows, so a second read never raises the strobe at once.
    task automatic read_status(output logic [7:0] byte_o);
        status_read_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        status_read_o = 1'b0;
        byte_o = status_byte_i;
        @(posedge core_clk_i);
        #1;
    endtask

    // Restarting the switches is only honoured after a read saw the flag.
    task automatic write_highside(input logic [2:0] bits);
        highside_on_wr_o = 1'b1;
        highside_on_bits_o = bits;
        @(posedge core_clk_i);
        #1;
        highside_on_wr_o = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: fwi_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fwi_top_test;
    // --------
    // Design hookup
    // --------
    localparam int IRQ_W = 8;
    logic core_clk_i, resetn_i, wd_cfg, uv, ov, rh, lin_fail, wk1, wk2, lin_rx, sel_n;
    fwi_pkg::fwi_mode_t mode_i;
    logic [2:0] hs_hot, hs_bits, hs_en;
    logic rd, hs_wr, irq_n, rst_n, reg_on, reg_lim, wd_en, wd_win, wd_to;
    logic tx_en, lwake_en, amp_en, wake;
    logic [7:0] status, b;
    logic [10:0] mvec;
    int errors, compares, w, p0, n;
    logic [13:0] rows [6] = '{{3'h0, 11'h200}, {3'h1, 11'h6A7}, {3'h2, 11'h6EF},
                              {3'h3, 11'h710}, {3'h4, 11'h010}, {3'h5, 11'h200}};
    logic [7:0] fbit [4] = '{8'h10, 8'h20, 8'h08, 8'h04};

    assign mvec = {rst_n, reg_on, reg_lim, wd_en, wd_win, tx_en, lwake_en, amp_en, hs_en};

    fwi_top #(.NREQ_TIMEOUT_CYC(50), .LIN_WAKE_CYC(10), .IRQ_PULSE_CYC(IRQ_W)) u_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .mode_i(mode_i),
        .watchdog_cfg_en_i(wd_cfg), .undervolt_det_i(uv), .overvolt_det_i(ov),
        .regulator_hot_det_i(rh), .highside_hot_det_i(hs_hot), .lin_fail_det_i(lin_fail),
        .wake_input_one_i(wk1), .wake_input_two_i(wk2), .lin_rx_i(lin_rx),
        .spi_select_n_i(sel_n), .status_read_i(rd), .highside_on_wr_i(hs_wr),
        .highside_on_bits_i(hs_bits), .status_byte_o(status), .fault_irq_n_o(irq_n),
        .analog_reset_n_o(rst_n), .regulator_on_o(reg_on), .regulator_limit_o(reg_lim),
        .watchdog_en_o(wd_en), .watchdog_window_o(wd_win), .watchdog_timeout_o(wd_to),
        .highside_en_o(hs_en), .lin_tx_en_o(tx_en), .lin_wake_en_o(lwake_en),
        .amp_en_o(amp_en), .wake_o(wake));

    fwi_mcu_model u_mcu (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .fault_irq_n_i(irq_n),
        .status_byte_i(status), .status_read_o(rd), .highside_on_wr_o(hs_wr),
        .highside_on_bits_o(hs_bits));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // --------
    // Helpers
    // --------
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask

    task automatic end_of_test();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic set_fault(input int k, input logic v);
        case (k)
            0: uv = v;
            1: ov = v;
            2: rh = v;
            default: hs_hot = {1'b0, v, 1'b0};
        endcase
    endtask

    // Bounded wait for the pulse, then its width in cycles.
    task automatic wait_irq(output int width);
        int k;
        k = 0;
        width = 0;
        while (irq_n !== 1'b0 && k < 40) begin
            cyc(1);
            k++;
        end
        if (k == 40) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
            end_of_test();
        end
        while (irq_n === 1'b0 && width < 300) begin
            cyc(1);
            width++;
        end
        if (width == 300) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            end_of_test();
        end
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        errors = 0;
        compares = 0;
        resetn_i = 1'b0;
        mode_i = fwi_pkg::FWI_MODE_RESET;
        {wd_cfg, uv, ov, rh, lin_fail, wk1, wk2, hs_hot} = 10'h200;
        lin_rx = 1'b1;
        sel_n = 1'b1;
        repeat (12) @(posedge core_clk_i);
        #1;
        resetn_i = 1'b1;
        cyc(4);
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h000);
        chk({10'h0, irq_n}, 11'h001);
        $display("test reset done");
        mode_i = fwi_pkg::FWI_MODE_NORMAL;
        u_mcu.write_highside(3'h7);
        cyc(2);
        for (int i = 0; i < 6; i++) begin
            mode_i = fwi_pkg::fwi_mode_t'(rows[i][13:11]);
            cyc(1);
            chk(mvec, rows[i][10:0]);
        end
        $display("test mode table done");
        mode_i = fwi_pkg::FWI_MODE_NORMAL;
        cyc(2);
        for (int k = 0; k < 4; k++) begin
            set_fault(k, 1'b1);
            wait_irq(w);
            chk(11'(w), 11'(IRQ_W));
            u_mcu.read_status(b);
            chk({3'h0, b}, {3'h0, 8'h80 | fbit[k]});
            u_mcu.read_status(b);
            chk({3'h0, b}, {3'h0, fbit[k]});
            set_fault(k, 1'b0);
            cyc(4);
            u_mcu.read_status(b);
            chk({3'h0, b}, {3'h0, (k == 3) ? 8'h04 : 8'h00});
        end
        chk({8'h0, hs_en}, 11'h000);
        u_mcu.write_highside(3'h7);
        cyc(1);
        chk({8'h0, hs_en}, 11'h007);
        $display("test faults done");
        p0 = u_mcu.pulse_cnt;
        uv = 1'b1;
        cyc(1);
        ov = 1'b1;
        cyc(60);
        chk(11'(u_mcu.pulse_cnt - p0), 11'h002);
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h0B0);
        {uv, ov} = 2'b00;
        cyc(4);
        $display("test back to back done");
        mode_i = fwi_pkg::FWI_MODE_NORMAL_REQ;
        n = 0;
        while (wd_to !== 1'b1 && n < 80) begin
            cyc(1);
            n++;
        end
        chk(11'(n), 11'h032);
        if (n >= 80) begin
            end_of_test();
        end
        $display("test timeout done");
        mode_i = fwi_pkg::FWI_MODE_STOP;
        cyc(4);
        p0 = u_mcu.pulse_cnt;
        uv = 1'b1;
        cyc(20);
        chk(11'(u_mcu.pulse_cnt - p0), 11'h000);
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h000);
        uv = 1'b0;
        wk1 = 1'b1;
        wait_irq(w);
        chk(11'(w), 11'(IRQ_W));
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h081);
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h001);
        p0 = u_mcu.pulse_cnt;
        lin_rx = 1'b0;
        cyc(5);
        lin_rx = 1'b1;
        cyc(20);
        chk(11'(u_mcu.pulse_cnt - p0), 11'h000);
        lin_rx = 1'b0;
        cyc(14);
        lin_rx = 1'b1;
        wait_irq(w);
        u_mcu.read_status(b);
        chk({3'h0, b}, 11'h0C0);
        wk1 = 1'b0;
        wait_irq(w);
        u_mcu.read_status(b);
        p0 = u_mcu.pulse_cnt;
        sel_n = 1'b0;
        cyc(3);
        sel_n = 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk(11'(n), 11'h003);
        if (n >= 10) begin
            end_of_test();
        end
        cyc(20);
        chk(11'(u_mcu.pulse_cnt - p0), 11'h000);
        $display("test stop mode done");
        resetn_i = 1'b0;
        cyc(2);
        resetn_i = 1'b1;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (wake !== 1'b0) begin
                n++;
            end
        end
        chk(11'(n), 11'h000);
        chk({10'h0, irq_n}, 11'h001);
        chk({3'h0, status}, 11'h000);
        $display("test reset in stop done");
        mode_i = fwi_pkg::FWI_MODE_SLEEP;
        cyc(4);
        p0 = u_mcu.pulse_cnt;
        sel_n = 1'b0;
        cyc(3);
        sel_n = 1'b1;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (wake !== 1'b0) begin
                n++;
            end
        end
        chk(11'(n), 11'h000);
        wk2 = 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk(11'(n), 11'h003);
        if (n >= 10) begin
            end_of_test();
        end
        cyc(20);
        chk(11'(u_mcu.pulse_cnt - p0), 11'h000);
        $display("test sleep mode done");
        end_of_test();
    end
endmodule
`default_nettype wire
